/* include/otpcs_pkg.sv */
`default_nettype none
package otpcs_pkg;
  // Register indices of the trim, readback and revision words
  localparam logic [4:0] ADDR_RANGE_ONE = 5'h16;
  localparam logic [4:0] ADDR_RANGE_TWO = 5'h17;
  localparam logic [4:0] ADDR_DELTA_1   = 5'h18;
  localparam logic [4:0] ADDR_DELTA_2   = 5'h19;
  localparam logic [4:0] ADDR_DELTA_3   = 5'h1A;
  localparam logic [4:0] ADDR_TC_LOW    = 5'h1B;
  localparam logic [4:0] ADDR_TC_HIGH   = 5'h1C;
  localparam logic [4:0] ADDR_TC_SEL    = 5'h1D;
  localparam logic [4:0] ADDR_READBACK  = 5'h1E;
  localparam logic [4:0] ADDR_REVISION  = 5'h1F;
  // Widths and bit positions
  localparam int FUSE_W   = 40;
  localparam int CFG_W    = 39;
  localparam int WIN_W    = 10;
  localparam int RANGE_W  = 7;
  localparam int NIB_W    = 4;
  localparam int DATA_W   = 8;
  localparam int RD_W     = 10;
  localparam int PAR_BIT  = 8;
  localparam int LOCK_BIT = 39;
  // Fuse operation codes
  localparam logic [1:0] OP_NOP0    = 2'h0;
  localparam logic [1:0] OP_REFRESH = 2'h1;
  localparam logic [1:0] OP_PROGRAM = 2'h2;
  localparam logic [1:0] OP_NOP3    = 2'h3;
  // Operation durations in cycles
  localparam logic [7:0] REFRESH_CYC = 8'h10;
  localparam logic [7:0] PROGRAM_CYC = 8'h40;
  // Revision word field fill
  localparam logic [1:0] REV_TOP_ZERO = 2'h0;
  // Operation sequencer, Gray along idle-refresh-program
  typedef enum logic [1:0] {
    OTPCS_IDLE    = 2'b00,
    OTPCS_REFRESH = 2'b01,
    OTPCS_PROGRAM = 2'b11
  } otpcs_state_t;
endpackage : otpcs_pkg
`default_nettype wire

/* logic/otpcs_store.sv */
// Operation
// [RL1] Bit 8 is odd parity of trim data
// [RL2] Range trims per channel at 0x16, 0x17
// [RL3] Delta trims: channel two upper nibble
// [RL4] Tempco constants, higher number upper nibble
// [RL5] Bit 0 of 0x1D selects tempco use
// [RL6] Reading status clears its latched flags
// [RL7] Revision word, top two bits zero
// [RL8] Mask version 4:3, metal tune 1:0
// [RL9] Variant bit 5, package bit 2
// [RL10] Forty-bit fuse store programmable by host
// [RL11] Fuse contents give power-up configuration
// [RL12] Program once, lock at fuse 39
// [RL13] Fuse bits map fields in fixed order
// [RL14] Refresh presents addressed fuses in readback
// [RL15] Address selects ten-bit fuse window
// [RL16] Op 1 refresh, 2 program, else none
// [RL17] Program writes fields plus lock, if unlocked
// [RL18] Active flag high during any operation
// [RL19] Undervoltage while programming latches failure
// [RL20] Parity follows current trim data
`timescale 1ns/10ps
`default_nettype none
module otpcs_store
  import otpcs_pkg::*;
#(
  parameter logic       SINGLE_VARIANT = 1'b0,  // Arbitrary value
  parameter logic [1:0] MASK_VERSION   = 2'h0,  // Arbitrary value
  parameter logic       PKG_VARIANT    = 1'b0,  // Arbitrary value
  parameter logic [1:0] METAL_TUNE     = 2'h0   // Arbitrary value
) (
  input  wire logic              core_clk_in,             // System clock
  input  wire logic              nrst_in,                 // Sync reset, low
  input  wire logic              reg_rd_in,               // Register read strobe
  input  wire logic [4:0]        reg_addr_in,             // Register index
  input  wire logic [6:0]        chan_one_range_trim_in,  // Factory trim
  input  wire logic [6:0]        chan_two_range_trim_in,  // Factory trim
  input  wire logic [11:0]       chan_one_delta_trim_in,  // D3,D2,D1 nibbles
  input  wire logic [11:0]       chan_two_delta_trim_in,  // D3,D2,D1 nibbles
  input  wire logic [15:0]       tempco_trim_constant_in, // TC3..TC0 nibbles
  input  wire logic              tempco_usage_select_in,  // Tempco version
  input  wire logic [1:0]        fuse_op_in,              // Operation code
  input  wire logic              fuse_op_wr_in,           // Operation write strobe
  input  wire logic [1:0]        fuse_addr_in,            // Readback window
  input  wire logic [CFG_W-1:0]  cfg_fields_in,           // Fuse-mapped fields
  input  wire logic [FUSE_W-1:0] fuse_cells_in,           // Fuse array sense
  input  wire logic              supply_uv_in,            // Supply low, async pin
  input  wire logic              status_rd_in,            // Status register read
  output logic [RD_W-1:0]        reg_rdata_out,           // Read data
  output logic                   reg_rvalid_out,          // Read data valid
  output logic [CFG_W-1:0]       fuse_config_out,         // Fuse configuration
  output logic                   fuse_locked_out,         // Lock bit state
  output logic                   fuse_zap_out,            // Program enable
  output logic [FUSE_W-1:0]      fuse_zap_data_out,       // Program pattern
  output logic                   fuse_active_out,         // Operation running
  output logic                   fuse_fail_out            // Latched failure
);

  // Whole state of the block
  // One packed record keeps every flop under a single clocked process
  typedef struct packed {
    otpcs_state_t      st;        // Sequencer state
    logic [7:0]        cnt;       // Operation timer
    logic [FUSE_W-1:0] shadow;    // Sensed fuse copy
    logic [FUSE_W-1:0] zdata;     // Program pattern
    logic [WIN_W-1:0]  window;    // Readback word
    logic              fail;      // Latched failure
    logic [6:0]        rng1;      // Range trim one
    logic [6:0]        rng2;      // Range trim two
    logic [11:0]       dlt1;      // Delta trims one
    logic [11:0]       dlt2;      // Delta trims two
    logic [15:0]       tc;        // Tempco trims
    logic              tcsel;     // Tempco usage
    logic [RD_W-1:0]   rdata;     // Read data
    logic              rvalid;    // Read valid
    logic              uv_s1;     // Sync stage one
    logic              uv_s2;     // Sync stage two
  } otpcs_regs_t;

  otpcs_regs_t r;       // Registered state
  otpcs_regs_t next_r;  // Next state

  // Odd parity over a data byte
  // Ones count plus parity bit is always odd
  function automatic logic odd_par(input logic [DATA_W-1:0] d);
    odd_par = ~(^d);
  endfunction : odd_par

  // Trim word with parity on top
  function automatic logic [RD_W-1:0] trim_word(input logic [DATA_W-1:0] d);
    trim_word = {1'b0, odd_par(d), d};  // RL1 RL20
  endfunction : trim_word

  // Ten-bit fuse window select
  // Window index times ten gives the lowest fuse bit of the slice
  function automatic logic [WIN_W-1:0] fuse_win(input logic [FUSE_W-1:0] f,
                                                input logic [1:0]        a);
    fuse_win = f[a*WIN_W +: WIN_W];  // RL15
  endfunction : fuse_win

  logic [DATA_W-1:0] rev_word;  // Revision word
  logic              start_ok;  // Command can start

  // Revision word assembly
  // Top bits are tied low; the remaining fields come from parameters
  assign rev_word = {REV_TOP_ZERO, SINGLE_VARIANT, MASK_VERSION,  // RL7 RL8 RL9
                     PKG_VARIANT, METAL_TUNE};                    // RL8 RL9
  // A command is taken only while nothing runs
  assign start_ok = (r.st == OTPCS_IDLE) && fuse_op_wr_in;

  // Next-state logic
  // Trim inputs are mirrored one cycle late, so a read always sees
  // a word and its parity taken from the same sample
  // A failure set and a status read in one cycle keep the flag set,
  // so a fault arriving during the read is never lost
  always_comb begin
    // Hold every field unless a branch below moves it
    next_r = r;
    // Two flip-flops tame the asynchronous under-voltage pin;
    // only the second stage feeds any decision
    next_r.uv_s1 = supply_uv_in;
    next_r.uv_s2 = r.uv_s1;
    // Trim mirror tracks inputs each cycle
    // Inputs are levels, so no reset value is needed here
    next_r.rng1  = chan_one_range_trim_in;   // RL2
    next_r.rng2  = chan_two_range_trim_in;   // RL2
    next_r.dlt1  = chan_one_delta_trim_in;   // RL3
    next_r.dlt2  = chan_two_delta_trim_in;   // RL3
    next_r.tc    = tempco_trim_constant_in;  // RL4
    next_r.tcsel = tempco_usage_select_in;   // RL5
    // Failure clear by status read, set wins
    // Set is applied after the clear so it takes priority
    if (status_rd_in) begin
      next_r.fail = 1'b0;  // RL6 RL19
    end
    if ((r.st == OTPCS_PROGRAM) && r.uv_s2) begin
      next_r.fail = 1'b1;  // RL19
    end
    // Operation sequencer
    case (r.st)
      OTPCS_IDLE: begin
        // Commands are only taken here; refused programs stay idle
        if (start_ok && (fuse_op_in == OP_REFRESH)) begin
          next_r.st  = OTPCS_REFRESH;  // RL16
          next_r.cnt = REFRESH_CYC;
        end else if (start_ok && (fuse_op_in == OP_PROGRAM)
                     && !r.shadow[LOCK_BIT]) begin
          next_r.st    = OTPCS_PROGRAM;             // RL16 RL17 RL12
          next_r.cnt   = PROGRAM_CYC;
          next_r.zdata = {1'b1, cfg_fields_in};     // RL17 RL13
        end
      end
      OTPCS_REFRESH: begin
        // Last cycle loads the shadow and the readback window
        if (r.cnt == 8'h01) begin
          next_r.st     = OTPCS_IDLE;
          next_r.cnt    = 8'h00;
          next_r.shadow = fuse_cells_in;                       // RL10
          next_r.window = fuse_win(fuse_cells_in, fuse_addr_in);  // RL14
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      OTPCS_PROGRAM: begin
        // Shadow takes the burnt pattern without a fresh sense
        if (r.cnt == 8'h01) begin
          next_r.st     = OTPCS_IDLE;
          next_r.cnt    = 8'h00;
          next_r.shadow = r.zdata;  // RL10 RL12
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
        // Unused code falls back to idle
        next_r.st  = OTPCS_IDLE;
        next_r.cnt = 8'h00;
      end
    endcase
    // Register read port
    // Valid follows the strobe by one cycle; data is zero when idle
    next_r.rvalid = reg_rd_in;
    next_r.rdata  = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_RANGE_ONE: next_r.rdata = trim_word({1'b0, r.rng1});             // RL2
        ADDR_RANGE_TWO: next_r.rdata = trim_word({1'b0, r.rng2});             // RL2
        ADDR_DELTA_1:   next_r.rdata = trim_word({r.dlt2[3:0], r.dlt1[3:0]});   // RL3
        ADDR_DELTA_2:   next_r.rdata = trim_word({r.dlt2[7:4], r.dlt1[7:4]});   // RL3
        ADDR_DELTA_3:   next_r.rdata = trim_word({r.dlt2[11:8], r.dlt1[11:8]}); // RL3
        ADDR_TC_LOW:    next_r.rdata = trim_word(r.tc[7:0]);                  // RL4
        ADDR_TC_HIGH:   next_r.rdata = trim_word(r.tc[15:8]);                 // RL4
        ADDR_TC_SEL:    next_r.rdata = trim_word({7'h00, r.tcsel});           // RL5
        ADDR_READBACK:  next_r.rdata = r.window;                              // RL14
        ADDR_REVISION:  next_r.rdata = {2'h0, rev_word};                      // RL7
        default:        next_r.rdata = '0;
      endcase
    end
  end

  // State register, boots with a refresh
  // Reset starts a refresh so the fuse contents reach the outputs
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      r     <= '0;
      r.st  <= OTPCS_REFRESH;  // RL11
      r.cnt <= REFRESH_CYC;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  // Zap and active are decoded from the state register, so they
  // stay glitch-free and change only on clock edges
  assign reg_rdata_out     = r.rdata;
  assign reg_rvalid_out    = r.rvalid;
  assign fuse_config_out   = r.shadow[CFG_W-1:0];  // RL11 RL13
  assign fuse_locked_out   = r.shadow[LOCK_BIT];   // RL12
  assign fuse_zap_out      = (r.st == OTPCS_PROGRAM);
  assign fuse_zap_data_out = r.zdata;
  assign fuse_active_out   = (r.st != OTPCS_IDLE); // RL18
  assign fuse_fail_out     = r.fail;

  // Assertions share the core clock and drop out during reset
  // Checks below watch the registered state, the outputs and the inputs
  // Read checks look one cycle after the strobe, where data stands
  // Timing checks use the package cycle counts as fixed delays,
  // so a change of those counts must be carried into them too
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // Every mapped trim word carries odd parity over its byte
  a_trim_parity: assert property (  // RL1
    r.rvalid && (r.rdata[PAR_BIT+1] == 1'b0)
    && ($past(reg_addr_in) >= ADDR_RANGE_ONE)
    && ($past(reg_addr_in) < ADDR_READBACK)
    |-> ^r.rdata[PAR_BIT:0])
    else $error("trim parity not odd");
  // Revision word keeps its top bits clear
  a_rev_word: assert property (  // RL7
    $past(reg_rd_in) && $past(reg_addr_in) == ADDR_REVISION
    |-> r.rdata[RD_W-1:6] == 4'h0 && r.rdata[4:3] == MASK_VERSION)
    else $error("revision word wrong");
  // Channel one range trim reads back with bit 7 clear
  a_range_read: assert property (  // RL2
    reg_rd_in && reg_addr_in == ADDR_RANGE_ONE
    |=> r.rdata[6:0] == $past(r.rng1) && !r.rdata[7])
    else $error("range trim read wrong");
  // Channel two range trim reads back the same way
  a_range_two: assert property (  // RL2
    reg_rd_in && reg_addr_in == ADDR_RANGE_TWO
    |=> r.rdata[6:0] == $past(r.rng2) && !r.rdata[7])
    else $error("range trim two read wrong");
  // Channel two delta sits in the upper nibble
  a_delta_nibble: assert property (  // RL3
    reg_rd_in && reg_addr_in == ADDR_DELTA_1
    |=> r.rdata[7:4] == $past(r.dlt2[3:0]))
    else $error("delta nibble order wrong");
  // Channel one delta sits in the lower nibble
  a_delta_low: assert property (  // RL3
    reg_rd_in && reg_addr_in == ADDR_DELTA_1
    |=> r.rdata[3:0] == $past(r.dlt1[3:0]))
    else $error("delta low nibble wrong");
  // Higher-numbered tempco constants sit in the upper register
  a_tc_order: assert property (  // RL4
    reg_rd_in && reg_addr_in == ADDR_TC_HIGH
    |=> r.rdata[7:0] == $past(r.tc[15:8]))
    else $error("tempco order wrong");
  // Tempco usage bit stands alone in bit 0
  a_tc_select: assert property (  // RL5
    reg_rd_in && reg_addr_in == ADDR_TC_SEL
    |=> r.rdata[7:0] == {7'h00, $past(r.tcsel)})
    else $error("tempco select wrong");
  // Variant, package and tune fields of the revision word
  a_rev_fields: assert property (  // RL9
    $past(reg_rd_in) && $past(reg_addr_in) == ADDR_REVISION
    |-> r.rdata[5] == SINGLE_VARIANT && r.rdata[2] == PKG_VARIANT
    && r.rdata[1:0] == METAL_TUNE)
    else $error("revision fields wrong");
  // Locked store never enters programming
  a_lock_refuse: assert property (  // RL12
    r.st == OTPCS_IDLE && r.shadow[LOCK_BIT] |=> r.st != OTPCS_PROGRAM)
    else $error("program taken while locked");
  // Lock bit once seen is never lost
  a_lock_stays: assert property (  // RL12
    fuse_locked_out |=> fuse_locked_out)
    else $error("lock bit lost");
  // Refresh holds the active flag for its first eight cycles and drops it sixteen cycles after start
  a_refresh_len: assert property (  // RL18
    $rose(r.st == OTPCS_REFRESH) |-> fuse_active_out [*8] ##9 !fuse_active_out)
    else $error("refresh length wrong");
  // Programming still holds zap 63 cycles after it rises and drops it on the next cycle
  a_prog_len: assert property (  // RL18
    $rose(fuse_zap_out) |-> ##63 fuse_zap_out ##1 !fuse_zap_out)
    else $error("program length wrong");
  // A running operation is not disturbed by a command write
  a_busy_ignore: assert property (  // RL18
    r.st != OTPCS_IDLE && r.cnt != 8'h01 |=> r.st == $past(r.st))
    else $error("busy sequencer moved");
  // Lock bit is set once programming ends
  a_prog_lock: assert property (  // RL17
    $fell(fuse_zap_out) |-> fuse_locked_out)
    else $error("lock bit not set after program");
  // Burn pattern always carries the lock bit
  a_zap_lock_bit: assert property (  // RL17
    fuse_zap_out |-> fuse_zap_data_out[LOCK_BIT])
    else $error("burn pattern lacks lock");
  // Mapped fields are captured at program start
  a_cfg_capture: assert property (  // RL13
    start_ok && fuse_op_in == OP_PROGRAM && !r.shadow[LOCK_BIT]
    |=> r.zdata == {1'b1, $past(cfg_fields_in)})
    else $error("fields not captured");
  // Refresh end copies the sensed array
  a_refresh_shadow: assert property (  // RL10
    r.st == OTPCS_REFRESH && r.cnt == 8'h01 |=> r.shadow == $past(fuse_cells_in))
    else $error("shadow not loaded");
  // Under-voltage while programming latches the failure
  a_fail_set: assert property (  // RL19
    r.st == OTPCS_PROGRAM && r.uv_s2 |=> fuse_fail_out)
    else $error("failure flag not set");
  // Failure flag holds until a status read
  a_fail_hold: assert property (  // RL19
    fuse_fail_out && !status_rd_in |=> fuse_fail_out)
    else $error("failure flag dropped");
  // Status read clears the failure unless a new one arrives
  a_fail_clear: assert property (  // RL6
    status_rd_in && !(r.st == OTPCS_PROGRAM && r.uv_s2) |=> !fuse_fail_out)
    else $error("failure flag not cleared");
  // No-op codes leave the sequencer idle
  a_nop_ignored: assert property (  // RL16
    start_ok && (fuse_op_in == OP_NOP0 || fuse_op_in == OP_NOP3)
    |=> r.st == OTPCS_IDLE)
    else $error("no-op started an operation");
  // Readback takes the addressed window at refresh end
  a_window_load: assert property (  // RL15
    r.st == OTPCS_REFRESH && r.cnt == 8'h01
    |=> r.window == fuse_win($past(fuse_cells_in), $past(fuse_addr_in)))
    else $error("readback window wrong");
  // Refresh ends with the active flag low
  a_refresh_done: assert property (  // RL14
    r.st == OTPCS_REFRESH && r.cnt == 8'h01 |=> !fuse_active_out)
    else $error("refresh did not end");

endmodule : otpcs_store
`default_nettype wire

/* verification/otpcs_fuse_model.sv */
`timescale 1ns/10ps
`default_nettype none
module otpcs_fuse_model
  import otpcs_pkg::*;
#(
  parameter logic [FUSE_W-1:0] INIT_CELLS = 40'h00_0000_0000  // Cells blown at power-up
) (
  input  wire logic              core_clk_in,  // System clock
  input  wire logic              zap_in,       // Program enable
  input  wire logic [FUSE_W-1:0] zap_data_in,  // Program pattern
  output logic [FUSE_W-1:0]      cells_out     // Sensed fuse array
);
  // Fuse contents survive any reset of the logic
  logic [FUSE_W-1:0] cells_q = INIT_CELLS;
  // A blown cell stays blown, so burning only adds ones
  always @(posedge core_clk_in) begin
    if (zap_in) begin
      cells_q <= cells_q | zap_data_in;
    end
  end
  assign cells_out = cells_q;
endmodule : otpcs_fuse_model
`default_nettype wire

/* verification/tb_otp_trim_config_store.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_otp_trim_config_store;
  import otpcs_pkg::*;
  localparam logic [FUSE_W-1:0] INIT = 40'h12_3456_789A;  // Fuses at power-up, lock clear
  localparam logic [CFG_W-1:0]  CFG  = 39'h55_AAAA_5555;  // Fields to program
  localparam logic [FUSE_W-1:0] BURNT = INIT | {1'b1, CFG};  // Fuses after programming
  logic clk, nrst, rd, op_wr, uv, st_rd, rvalid, locked, zap, active, fail;
  logic [4:0]        addr;     // Register index
  logic [1:0]        op;       // Operation code
  logic [1:0]        faddr;    // Readback window
  logic [6:0]        trim1;    // Channel one range trim
  logic              tcsel;    // Tempco usage select
  logic [CFG_W-1:0]  cfg;      // Fields to program
  logic [9:0]        rdata;    // Read data
  logic [CFG_W-1:0]  cfg_out;  // Fuse configuration
  logic [FUSE_W-1:0] zdata;    // Program pattern
  logic [FUSE_W-1:0] cells;    // Sensed fuses
  int                failures = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  // Trim word: odd parity over the data byte below it
  function automatic logic [9:0] pw(input logic [7:0] d);
    return {1'b0, ~^d, d};
  endfunction : pw
  // Register rows: index beside the word it must read back
  localparam logic [4:0] RA [11] = '{ADDR_RANGE_ONE, ADDR_RANGE_TWO, ADDR_DELTA_1,
    ADDR_DELTA_2, ADDR_DELTA_3, ADDR_TC_LOW, ADDR_TC_HIGH, ADDR_TC_SEL, ADDR_REVISION,
    5'h05, ADDR_READBACK};
  localparam logic [9:0] RE [11] = '{pw(8'h5A), pw(8'h23), pw(8'h13), pw(8'hC5), pw(8'h6A),
    pw(8'h27), pw(8'h9E), pw(8'h01), 10'h017, 10'h000, INIT[9:0]};
  otpcs_store #(.SINGLE_VARIANT(1'b0), .MASK_VERSION(2'h2), .PKG_VARIANT(1'b1),
    .METAL_TUNE(2'h3)) DUT (
    .core_clk_in(clk), .nrst_in(nrst), .reg_rd_in(rd), .reg_addr_in(addr),
    .chan_one_range_trim_in(trim1), .chan_two_range_trim_in(7'h23),
    .chan_one_delta_trim_in(12'hA53), .chan_two_delta_trim_in(12'h6C1),
    .tempco_trim_constant_in(16'h9E27), .tempco_usage_select_in(tcsel),
    .fuse_op_in(op), .fuse_op_wr_in(op_wr), .fuse_addr_in(faddr), .cfg_fields_in(cfg),
    .fuse_cells_in(cells), .supply_uv_in(uv), .status_rd_in(st_rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .fuse_config_out(cfg_out),
    .fuse_locked_out(locked), .fuse_zap_out(zap), .fuse_zap_data_out(zdata),
    .fuse_active_out(active), .fuse_fail_out(fail));
  otpcs_fuse_model #(.INIT_CELLS(INIT)) fuses (.core_clk_in(clk), .zap_in(zap),
    .zap_data_in(zdata), .cells_out(cells));
  // Free-running clock, 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      end_of_test();
    end
  end
  // Compare one value and count it
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check
  // One read taken at the next edge; strobe is left high for back-to-back use
  task automatic rd_chk(input logic [4:0] a, input logic [9:0] e);
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    check(rvalid, 1'b1);
    check(rdata, e);
  endtask : rd_chk
  // Issue an operation and measure how long it stays active
  task automatic fuse_cmd(input logic [1:0] code, input int len);
    int n;
    op = code;
    op_wr = 1'b1;
    @(posedge clk);
    #1;
    op_wr = 1'b0;
    if (code == OP_PROGRAM && len != 0) check(zdata, {1'b1, CFG});
    for (n = 0; n < 100 && active !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    check(n, len);
  endtask : fuse_cmd
  // Boot refresh after reset: active for the refresh length, then idle
  task automatic boot_wait();
    check(active, 1'b1);
    repeat (int'(REFRESH_CYC)) @(posedge clk);
    #1;
    check(active, 1'b0);
  endtask : boot_wait
  // Closing report
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    {rd, op_wr, uv, st_rd, op, faddr, addr, nrst} = '0;
    trim1 = 7'h5A;
    tcsel = 1'b1;
    cfg = CFG;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    boot_wait();
    fuse_cmd(OP_NOP0, 0);
    check(cfg_out, INIT[CFG_W-1:0]);
    check(locked, 1'b0);
    for (int i = 0; i < 11; i++) rd_chk(RA[i], RE[i]);
    rd = 1'b0;
    fuse_cmd(OP_NOP3, 0);
    uv = 1'b1;
    fuse_cmd(OP_PROGRAM, int'(PROGRAM_CYC));
    uv = 1'b0;
    check({locked, cfg_out}, {1'b1, CFG});
    check(fail, 1'b1);
    repeat (3) @(posedge clk);
    #1 st_rd = 1'b1;
    @(posedge clk);
    #1 st_rd = 1'b0;
    check(fail, 1'b0);
    fuse_cmd(OP_PROGRAM, 0);
    for (int a = 0; a < 4; a++) begin
      faddr = a[1:0];
      fuse_cmd(OP_REFRESH, int'(REFRESH_CYC));
      rd_chk(ADDR_READBACK, BURNT[a*10 +: 10]);
      rd = 1'b0;
    end
    trim1 = 7'h7F;
    repeat (2) @(posedge clk);
    #1 rd_chk(ADDR_RANGE_ONE, pw(8'h7F));
    rd = 1'b0;
    tcsel = 1'b0;
    repeat (2) @(posedge clk);
    #1 rd_chk(ADDR_TC_SEL, pw(8'h00));
    rd = 1'b0;
    @(posedge clk);
    #1 check(rvalid, 1'b0);
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    boot_wait();
    fuse_cmd(OP_NOP0, 0);
    check({locked, cfg_out}, BURNT);
    end_of_test();
  end
endmodule : tb_otp_trim_config_store
`default_nettype wire
